/* File: src/rtc_map.svh */
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// crystal ticks per second (32.768 kHz in, 1 Hz out)
`define RTC_XTAL_HZ       32768
`define RTC_TICK_HZ       1
`define RTC_PRESCALE_DIV  (`RTC_XTAL_HZ / `RTC_TICK_HZ)
`define RTC_PRESCALE_W    16

// counter limits
`define RTC_SEC_MAX       6'd59
`define RTC_MIN_MAX       6'd59
`define RTC_HOUR_MAX      5'd23
`define RTC_DAY_MAX       15'h7fff

// reset values
`define RTC_SEC_RST       6'h00
`define RTC_MIN_RST       6'h00
`define RTC_HOUR_RST      5'h00
`define RTC_DAY_RST       15'h0000
`define RTC_SW_RST        16'h0000
`define RTC_SW_MAX        16'hffff
`define RTC_PEND_RST      7'h00

// event bit positions
`define RTC_EV_SEC        0
`define RTC_EV_MIN        1
`define RTC_EV_HOUR       2
`define RTC_EV_DAY        3
`define RTC_EV_ALARM      4
`define RTC_EV_DAY_ALARM  5
`define RTC_EV_SW         6
`define RTC_EV_NUM        7

`endif

/* File: src/rtc_pkg.sv */
package rtc_pkg;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } rtc_tod_s;

    typedef struct packed {
        logic [14:0] day;
        rtc_tod_s    tod;
    } rtc_time_s;

    typedef logic [6:0]  rtc_ev_t;
    typedef logic [15:0] rtc_sw_t;

endpackage

/* File: src/rtc_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"

module rtc_prescale
    import rtc_pkg::*;
#(
    parameter int DIV = `RTC_PRESCALE_DIV
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic run,
    input  wire logic xtal_tick,
    output logic      sec_tick
);

    localparam logic [`RTC_PRESCALE_W-1:0] LAST = (`RTC_PRESCALE_W)'(DIV - 1);

    logic [`RTC_PRESCALE_W-1:0] cnt;

    // one output pulse per DIV crystal ticks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt      <= '0;
            sec_tick <= 1'b0;
        end else if (!run) begin
            cnt      <= '0;
            sec_tick <= 1'b0;
        end else if (xtal_tick) begin
            if (cnt == LAST) begin // [R01]
                cnt      <= '0;
                sec_tick <= 1'b1;
            end else begin
                cnt      <= cnt + 1'b1;
                sec_tick <= 1'b0;
            end
        end else begin
            sec_tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: src/rtc_core.sv */
// What this block does
// [R01] prescaler divides crystal ticks to one hertz
// [R02] seconds, minutes, hours, 32768-day counters
// [R03] selectable second, minute, hour, day interrupts
// [R04] enabled alarm interrupts on time match
// [R05] daily alarm plus day-and-time alarm
// [R06] stopwatch loads count, decrements each second
// [R07] stopwatch underflow past zero raises interrupt
// [R08] enabled events wake processor from sleep
// [R09] wakeup also exits deep sleep, hibernate
// [R10] each wrap carries into next counter
// [R11] pending flags stay set until cleared
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"

module rtc_core
    import rtc_pkg::*;
#(
    parameter int PRESCALE_DIV = `RTC_PRESCALE_DIV
) (
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      xtal_tick,
    input  wire logic      rtc_run,
    input  wire logic      time_load,
    input  wire rtc_time_s time_load_val,
    input  wire logic      alarm_en,
    input  wire rtc_tod_s  alarm_tod,
    input  wire logic      day_alarm_en,
    input  wire rtc_time_s day_alarm_time,
    input  wire logic      sw_en,
    input  wire logic      sw_load,
    input  wire rtc_sw_t   sw_load_val,
    input  wire rtc_ev_t   int_en,
    input  wire rtc_ev_t   int_clr,
    input  wire logic      deep_wake_en,
    input  wire logic      hib_wake_en,
    output rtc_time_s      cur_time,
    output rtc_sw_t        sw_count,
    output rtc_ev_t        pending,
    output logic           sec_tick,
    output logic           irq,
    output logic           wake_sleep,
    output logic           wake_deep_sleep,
    output logic           hib_exit
);

    rtc_time_s next_time;
    rtc_ev_t   ev;
    logic      wrap_sec;
    logic      wrap_min;
    logic      wrap_hour;
    logic      alarm_hit;
    logic      day_alarm_hit;
    logic      sw_underflow;
    logic      wake_any;

    function automatic logic tod_eq(input rtc_tod_s a, input rtc_tod_s b);
        tod_eq = (a.hour == b.hour) && (a.min == b.min) && (a.sec == b.sec);
    endfunction

    function automatic logic [5:0] inc_mod6(input logic [5:0] v, input logic [5:0] max);
        inc_mod6 = (v == max) ? 6'h00 : v + 6'h01;
    endfunction

    rtc_prescale #(
        .DIV (PRESCALE_DIV)
    ) u_prescale (
        .clk       (clk),
        .rst_b     (rst_b),
        .run       (rtc_run),
        .xtal_tick (xtal_tick),
        .sec_tick  (sec_tick)
    );

    // carry chain from seconds up to days
    always_comb begin
        wrap_sec  = (cur_time.tod.sec == `RTC_SEC_MAX);                 // [R10]
        wrap_min  = wrap_sec && (cur_time.tod.min == `RTC_MIN_MAX);      // [R10]
        wrap_hour = wrap_min && (cur_time.tod.hour == `RTC_HOUR_MAX);    // [R10]
        next_time = cur_time;
        next_time.tod.sec = inc_mod6(cur_time.tod.sec, `RTC_SEC_MAX);   // [R02]
        if (wrap_sec) begin
            next_time.tod.min = inc_mod6(cur_time.tod.min, `RTC_MIN_MAX); // [R02]
        end
        if (wrap_min) begin
            next_time.tod.hour = (cur_time.tod.hour == `RTC_HOUR_MAX) ? 5'h00
                                                                      : cur_time.tod.hour + 5'h01; // [R02]
        end
        if (wrap_hour) begin
            next_time.day = cur_time.day + 15'h0001; // [R02] wraps after 32768 days
        end
    end

    // load from software has priority over the tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_time.day      <= `RTC_DAY_RST;
            cur_time.tod.hour <= `RTC_HOUR_RST;
            cur_time.tod.min  <= `RTC_MIN_RST;
            cur_time.tod.sec  <= `RTC_SEC_RST;
        end else if (time_load) begin
            cur_time <= time_load_val;
        end else if (sec_tick) begin
            cur_time <= next_time; // [R01]
        end
    end

    // matches are judged on the value the tick is about to store
    always_comb begin
        alarm_hit     = alarm_en && sec_tick && !time_load
                        && tod_eq(next_time.tod, alarm_tod);                     // [R04] [R05]
        day_alarm_hit = day_alarm_en && sec_tick && !time_load
                        && tod_eq(next_time.tod, day_alarm_time.tod)
                        && (next_time.day == day_alarm_time.day);                // [R04] [R05]
    end

    // stopwatch counts down once a second; below zero it wraps to all ones
    assign sw_underflow = sw_en && sec_tick && !sw_load && (sw_count == `RTC_SW_RST); // [R07]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_count <= `RTC_SW_RST;
        end else if (sw_load) begin
            sw_count <= sw_load_val; // [R06]
        end else if (sw_en && sec_tick) begin
            sw_count <= (sw_count == `RTC_SW_RST) ? `RTC_SW_MAX : sw_count - 16'h0001; // [R06]
        end
    end

    // raw events, each one cycle long
    always_comb begin
        ev = '0;
        ev[`RTC_EV_SEC]       = sec_tick && !time_load;             // [R03]
        ev[`RTC_EV_MIN]       = sec_tick && !time_load && wrap_sec;  // [R03]
        ev[`RTC_EV_HOUR]      = sec_tick && !time_load && wrap_min;  // [R03]
        ev[`RTC_EV_DAY]       = sec_tick && !time_load && wrap_hour; // [R03]
        ev[`RTC_EV_ALARM]     = alarm_hit;
        ev[`RTC_EV_DAY_ALARM] = day_alarm_hit;
        ev[`RTC_EV_SW]        = sw_underflow;
    end

    // sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= `RTC_PEND_RST;
        end else begin
            pending <= (pending & ~int_clr) | (ev & int_en); // [R11] [R03]
        end
    end

    assign wake_any = |(pending & int_en);

    assign irq             = wake_any;
    assign wake_sleep      = wake_any;                 // [R08]
    assign wake_deep_sleep = wake_any && deep_wake_en; // [R09]
    assign hib_exit        = wake_any && hib_wake_en;  // [R09]

endmodule

`default_nettype wire

/* File: sim/rtc_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_core_asserts
    import rtc_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst_b,
    input wire logic      time_load,
    input wire logic      alarm_en,
    input wire rtc_tod_s  alarm_tod,
    input wire logic      sw_en,
    input wire logic      sw_load,
    input wire rtc_ev_t   int_en,
    input wire rtc_ev_t   int_clr,
    input wire logic      deep_wake_en,
    input wire logic      hib_wake_en,
    input wire rtc_time_s cur_time,
    input wire rtc_sw_t   sw_count,
    input wire rtc_ev_t   pending,
    input wire logic      sec_tick,
    input wire logic      irq,
    input wire logic      wake_sleep,
    input wire logic      wake_deep_sleep,
    input wire logic      hib_exit
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence tick_s;
        sec_tick && !time_load;
    endsequence
    sequence sw_tick_s;
        sec_tick && sw_en && !sw_load;
    endsequence
    chk_irq_gate: assert property (irq == |(pending & int_en))
        else $error("irq gate");
    chk_wake_gate: assert property (wake_sleep == irq && wake_deep_sleep == (irq && deep_wake_en)
        && hib_exit == (irq && hib_wake_en)) else $error("wake gate");
    chk_tick_pulse: assert property (sec_tick |=> !sec_tick)
        else $error("tick width");
    chk_sec_carry: assert property (tick_s ##0 cur_time.tod.sec == 6'h3b |=> cur_time.tod.sec == 6'h00
        && cur_time.tod.min != $past(cur_time.tod.min)) else $error("no carry");
    chk_time_hold: assert property (!sec_tick && !time_load |=> $stable(cur_time))
        else $error("time moved");
    chk_sec_event: assert property (tick_s ##0 int_en[0] |=> pending[0])
        else $error("second event lost");
    chk_alarm_hit: assert property (tick_s ##0 alarm_en && int_en[4] ##1 cur_time.tod == $past(alarm_tod)
        |-> pending[4]) else $error("alarm missed");
    chk_sw_dec: assert property (sw_tick_s ##0 sw_count != 16'h0000 |=> sw_count == $past(sw_count) - 16'h0001)
        else $error("stopwatch step");
    chk_sw_under: assert property (sw_tick_s ##0 sw_count == 16'h0000 && int_en[6]
        |=> sw_count == 16'hffff && pending[6]) else $error("underflow");
    chk_pend_hold: assert property (1'b1 |=> &(pending | $past(int_clr) | ~$past(pending)))
        else $error("pending dropped");
endmodule
bind rtc_core rtc_core_asserts rtc_core_asserts_inst (.clk, .rst_b, .time_load, .alarm_en, .alarm_tod, .sw_en,
    .sw_load, .int_en, .int_clr, .deep_wake_en, .hib_wake_en, .cur_time, .sw_count, .pending, .sec_tick, .irq,
    .wake_sleep, .wake_deep_sleep, .hib_exit);
`default_nettype wire

/* File: sim/rtc_core_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_core_host
    import rtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       wake_sleep,
    input  wire rtc_ev_t    pending,
    input  wire logic       svc_on,
    input  wire logic [2:0] slow,
    output rtc_ev_t         int_clr
);
    logic [2:0] wait_cnt;
    // core wakes, spends slow cycles, then clears what it saw pending
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 3'h0;
            int_clr  <= 7'h00;
        end else begin
            int_clr  <= 7'h00;
            wait_cnt <= (wake_sleep && svc_on) ? wait_cnt + 3'h1 : 3'h0;
            if (wake_sleep && svc_on && wait_cnt == slow) begin
                int_clr  <= pending;
                wait_cnt <= 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/rtc_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_core_tb
    import rtc_pkg::*;
;
    logic      clk = 1'b0, xtal_tick = 1'b0, rst_b, rtc_run, time_load, alarm_en, day_alarm_en, sw_en, sw_load;
    logic      deep_wake_en, hib_wake_en, svc_on, sec_tick, irq, wake_sleep, wake_deep_sleep, hib_exit;
    rtc_time_s time_load_val, day_alarm_time, cur_time;
    rtc_tod_s  alarm_tod;
    rtc_sw_t   sw_load_val, sw_count;
    rtc_ev_t   int_en, int_clr, pending;
    int        n_errors = 0, checked = 0, n;
    always #2.5 clk = ~clk;
    always @(posedge clk) xtal_tick <= #1 ~xtal_tick;
    rtc_core #(.PRESCALE_DIV(4)) rtc_core_inst (.clk, .rst_b, .xtal_tick, .rtc_run, .time_load, .time_load_val,
        .alarm_en, .alarm_tod, .day_alarm_en, .day_alarm_time, .sw_en, .sw_load, .sw_load_val, .int_en, .int_clr,
        .deep_wake_en, .hib_wake_en, .cur_time, .sw_count, .pending, .sec_tick, .irq, .wake_sleep,
        .wake_deep_sleep, .hib_exit);
    rtc_core_host rtc_core_host_inst (.clk, .rst_b, .wake_sleep, .pending, .svc_on, .slow(3'h5), .int_clr);
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int c);
        for (n = 1; n < c && sec_tick !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic tick();
        cyc(40);
        if (n == 40) begin
            cmp(32'h0, 32'h1);
            tally_and_finish();
        end
        @(posedge clk);
        #1;
    endtask
    task automatic load(input rtc_time_s t);
        time_load_val = t;
        time_load = 1'b1;
        @(posedge clk);
        #1 time_load = 1'b0;
    endtask
    task automatic t_prescale();
        cyc(20);
        cmp(n, 20);
        rtc_run = 1'b1;
        tick();
        cyc(20);
        cmp(n, 8);
    endtask
    task automatic t_carry();
        int_en = 7'h0f;
        load({15'h7fff, 5'h17, 6'h3b, 6'h3b});
        tick();
        cmp(cur_time, 32'h0);
        repeat (9) @(posedge clk);
        #1;
        cmp({pending, irq}, 8'h1f);
        rtc_run = 1'b0;
        svc_on = 1'b1;
        for (n = 0; n < 30 && pending !== 7'h00; n++) begin
            @(posedge clk);
            #1;
        end
        cmp(pending, 7'h00);
        if (n == 30) begin
            tally_and_finish();
        end
        {rtc_run, int_en} = 8'h80;
        tick();
        cmp(pending, 7'h00);
    endtask
    task automatic t_alarm();
        {svc_on, alarm_en, day_alarm_en, deep_wake_en, int_en} = 11'h3b0;
        alarm_tod = {5'h0a, 6'h00, 6'h01};
        day_alarm_time = {15'h0003, 5'h0a, 6'h00, 6'h01};
        load({15'h0004, 5'h0a, 6'h00, 6'h00});
        tick();
        cmp(pending, 7'h10);
        load({15'h0003, 5'h0a, 6'h00, 6'h00});
        tick();
        cmp(pending, 7'h30);
        cmp({wake_sleep, wake_deep_sleep, hib_exit}, 3'h6);
        hib_wake_en = 1'b1;
        #1;
        cmp({wake_sleep, wake_deep_sleep, hib_exit}, 3'h7);
    endtask
    task automatic t_sw();
        {int_en, sw_en, sw_load, sw_load_val} = {7'h40, 2'h3, 16'h0001};
        @(posedge clk);
        #1 sw_load = 1'b0;
        tick();
        cmp(sw_count, 16'h0000);
        tick();
        cmp({sw_count, pending[6]}, 17'h1ffff);
    endtask
    initial begin
        {rst_b, rtc_run, time_load, alarm_en, day_alarm_en, sw_en, sw_load, deep_wake_en, hib_wake_en, svc_on} = '0;
        {time_load_val, alarm_tod, day_alarm_time, sw_load_val, int_en} = '0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        t_prescale();
        t_carry();
        t_alarm();
        t_sw();
        tally_and_finish();
    end
endmodule
`default_nettype wire
